//--- rtl/cms_sequencer.sv
// configuration mode sequencer: power-on delay, load, init, user mode
// phases run power-on wait, load, register reset, i/o release, user
// outputs are registered from the next phase, so they move with it
// the power-on wait is counted in i_clk cycles; a slower clock
// stretches it, so the delay parameters must follow the real clock
// the strap is taken once; pull-up and request pins are live levels
// limitation: a request held low during the wait is only seen after it
// i/o and pull-up enables are meant for the pad ring, not for logic
// assumes pins are synchronous to i_clk and i_rst marks power-up
// assumes the loader raises i_config_done only while o_config_load is high
`timescale 1ns/1ns
`default_nettype none
`include "cms_defs.svh"
module cms_sequencer #(
  parameter int unsigned POR_LONG_CYC = `CMS_POR_LONG_CYC,
  parameter int unsigned POR_SHORT_CYC = `CMS_POR_SHORT_CYC
) (
  // clock and power-up reset
  input wire logic i_clk,
  input wire logic i_rst,
  // straps and request pin
  input wire logic i_por_delay_select,
  input wire logic i_config_pullup_disable,
  input wire logic i_reconfig_request_n,
  // configuration load handshake
  input wire logic i_config_done,
  output logic o_config_load,
  // mode and i/o control
  output cms_pkg::cms_status_t o_status
);
  import cms_pkg::*;

  // strap group: delay choice latched once per power-up
  logic strap_taken_q, strap_taken_d;
  logic [`CMS_CNT_W-1:0] por_limit_q, por_limit_d;

  // mode group: phase and the one counter all timed phases share
  cms_state_t state_q, state_d;
  logic [`CMS_CNT_W-1:0] cnt_q, cnt_d;
  logic por_expired;
  logic init_expired;
  logic reload_req;

  // pin group: everything the outside world sees
  logic load_q, load_d;
  cms_status_t status_q, status_d;

  // terminal values cut to counter width; the long delay needs all 23 bits, the short one only 20
  localparam logic [`CMS_CNT_W-1:0] POR_SHORT_LIM = POR_SHORT_CYC[`CMS_CNT_W-1:0];
  localparam logic [`CMS_CNT_W-1:0] POR_LONG_LIM = POR_LONG_CYC[`CMS_CNT_W-1:0];
  localparam logic [`CMS_CNT_W-1:0] INIT_LIM = `CMS_CNT_W'(`CMS_INIT_CYC - 1);
  localparam logic [`CMS_CNT_W-1:0] CNT_ONE = `CMS_CNT_W'(1);

  // a strap that moves after power-up is ignored, as on a board
  always_comb begin
    strap_taken_d = 1'b1;
    por_limit_d = por_limit_q;
    if (!strap_taken_q) begin
      if (i_por_delay_select) begin
        por_limit_d = POR_SHORT_LIM;
      end else begin
        por_limit_d = POR_LONG_LIM;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      strap_taken_q <= 1'b0;
      por_limit_q <= '0;
    end else begin
      strap_taken_q <= strap_taken_d;
      por_limit_q <= por_limit_d;
    end
  end

  // shared terminal counts
  assign por_expired = (cnt_q >= por_limit_q - CNT_ONE);
  assign init_expired = (cnt_q == INIT_LIM);
  // no reload during the power-on wait: supplies may still be ramping
  assign reload_req = !i_reconfig_request_n && (state_q != CMS_POR);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      CMS_POR: begin
        // counting starts one edge after the strap is taken
        if (strap_taken_q) begin
          if (por_expired) begin
            state_d = CMS_CONFIG;
            cnt_d = '0;
          end else begin
            cnt_d = cnt_q + CNT_ONE;
          end
        end
      end

      CMS_CONFIG: begin
        // the load only counts once the request pin is released
        if (i_config_done && i_reconfig_request_n) begin
          state_d = CMS_INIT_RESET;
          cnt_d = '0;
        end
      end

      CMS_INIT_RESET: begin
        if (init_expired) begin
          state_d = CMS_INIT_IO;
        end else begin
          cnt_d = cnt_q + CNT_ONE;
        end
      end

      CMS_INIT_IO: begin
        state_d = CMS_USER;
      end

      CMS_USER: begin
        state_d = CMS_USER;
      end

      default: begin
        state_d = CMS_POR;
        cnt_d = '0;
      end
    endcase
    // request pin wins from any mode after the power-on delay
    if (reload_req) begin
      state_d = CMS_CONFIG;
      cnt_d = '0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= CMS_POR;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // outputs decode the next state so pins move on the edge the phase does
  always_comb begin
    load_d = 1'b0;
    status_d = `CMS_STATUS_RST;
    case (state_d)
      CMS_POR: begin
        load_d = 1'b0;
        status_d.command_mode = 1'b0;
        status_d.user_mode = 1'b0;
        status_d.io_enable = 1'b0;
        status_d.pullup_enable = !i_config_pullup_disable;
        status_d.user_reset = 1'b1;
      end

      CMS_CONFIG: begin
        // no load while the request pin is still held low
        load_d = i_reconfig_request_n;
        status_d.command_mode = 1'b1;
        status_d.user_mode = 1'b0;
        status_d.io_enable = 1'b0;
        status_d.pullup_enable = !i_config_pullup_disable;
        status_d.user_reset = 1'b1;
      end

      CMS_INIT_RESET: begin
        // user registers held in reset for the whole init count
        load_d = 1'b0;
        status_d.command_mode = 1'b1;
        status_d.user_mode = 1'b0;
        status_d.io_enable = 1'b0;
        status_d.pullup_enable = !i_config_pullup_disable;
        status_d.user_reset = 1'b1;
      end

      CMS_INIT_IO: begin
        // pull-ups only matter while i/o floats
        load_d = 1'b0;
        status_d.command_mode = 1'b1;
        status_d.user_mode = 1'b0;
        status_d.io_enable = 1'b1;
        status_d.pullup_enable = 1'b0;
        status_d.user_reset = 1'b0;
      end

      CMS_USER: begin
        load_d = 1'b0;
        status_d.command_mode = 1'b0;
        status_d.user_mode = 1'b1;
        status_d.io_enable = 1'b1;
        status_d.pullup_enable = 1'b0;
        status_d.user_reset = 1'b0;
      end

      default: begin
        load_d = 1'b0;
        status_d.command_mode = 1'b0;
        status_d.user_mode = 1'b0;
        status_d.io_enable = 1'b0;
        status_d.pullup_enable = !i_config_pullup_disable;
        status_d.user_reset = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      load_q <= 1'b0;
      status_q <= `CMS_STATUS_RST;
    end else begin
      load_q <= load_d;
      status_q <= status_d;
    end
  end

  assign o_config_load = load_q;
  assign o_status = status_q;
endmodule : cms_sequencer
`default_nettype wire

//--- rtl/cms_defs.svh
// constants for the configuration mode sequencer
// assumes a 50 MHz i_clk; included by the sequencer module only
`ifndef CMS_DEFS_SVH
`define CMS_DEFS_SVH
`define CMS_CLK_HZ 50000000
`define CMS_POR_LONG_MS 100
`define CMS_POR_SHORT_MS 12
`define CMS_POR_LONG_CYC ((`CMS_POR_LONG_MS * `CMS_CLK_HZ) / 1000)
`define CMS_POR_SHORT_CYC ((`CMS_POR_SHORT_MS * `CMS_CLK_HZ) / 1000)
`define CMS_INIT_CYC 8
`define CMS_CNT_W 23
`define CMS_STATUS_RST 5'h01
`endif

//--- rtl/cms_pkg.sv
// types for the configuration mode sequencer
// needs no defines; only the sequencer includes cms_defs.svh
package cms_pkg;
  typedef enum logic [2:0] {
    CMS_POR,
    CMS_CONFIG,
    CMS_INIT_RESET,
    CMS_INIT_IO,
    CMS_USER
  } cms_state_t;

  typedef struct packed {
    logic command_mode;
    logic user_mode;
    logic io_enable;
    logic pullup_enable;
    logic user_reset;
  } cms_status_t;
endpackage : cms_pkg

//--- tb/cms_assertions.sv
// sequencer port checks
// assumes async reset
`timescale 1ns/1ns
`default_nettype none
module cms_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_config_pullup_disable,
  input wire logic i_reconfig_request_n,
  input wire logic o_config_load,
  input wire cms_pkg::cms_status_t o_status
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_hiz; o_config_load |-> !o_status.io_enable; endproperty
  a_hiz: assert property (p_hiz) else $error("io on");
  property p_init; $fell(o_config_load) |->
    o_status.user_reset[*8] ##2 o_status.user_mode; endproperty
  a_init: assert property (p_init) else $error("init");
  property p_user; o_status.user_mode |-> !o_status.command_mode && o_status.io_enable
    && !o_status.user_reset && !o_config_load; endproperty
  a_user: assert property (p_user) else $error("user");
  property p_drop; !i_reconfig_request_n && o_status.user_mode |=>
    o_status.command_mode && !o_status.io_enable; endproperty
  a_drop: assert property (p_drop) else $error("drop");
  property p_held; !i_reconfig_request_n && o_status.command_mode |=>
    o_status.command_mode && !o_status.io_enable && !o_config_load; endproperty
  a_held: assert property (p_held) else $error("held");
  property p_pull; o_config_load |->
    o_status.pullup_enable == !$past(i_config_pullup_disable); endproperty
  a_pull: assert property (p_pull) else $error("pull");
  property p_por; !o_status.command_mode && !o_status.user_mode |->
    !o_status.io_enable && !o_config_load; endproperty
  a_por: assert property (p_por) else $error("por");
endmodule : cms_chk
bind cms_sequencer cms_chk u_chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_config_pullup_disable(i_config_pullup_disable),
  .i_reconfig_request_n(i_reconfig_request_n), .o_config_load(o_config_load),
  .o_status(o_status));
`default_nettype wire

//--- tb/cms_cfg_src.sv
// config source: done pulse a few cycles into a load
// assumes i_load is a registered level from the sequencer
`timescale 1ns/1ns
`default_nettype none
module cms_cfg_src (
  input wire logic i_clk,
  input wire logic i_load,
  output var logic o_done = 1'b0
);
  logic [1:0] n = 2'h0;
  always @(posedge i_clk) n <= i_load ? n + 2'h1 : 2'h0;
  always @(posedge i_clk) o_done <= i_load && n == 2'h3;
endmodule : cms_cfg_src
`default_nettype wire

//--- tb/tb_top.sv
// bench: power-up, load, user mode, reconfiguration
// assumes small delay parameters so both power-on waits stay short
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic i_clk = 0, i_rst = 1, s = 0, rq_n = 1, done, load;
  logic [4:0] st;
  int n_fail = 0, num_checks = 0, k;
  cms_sequencer #(.POR_LONG_CYC(20), .POR_SHORT_CYC(5)) dut (.i_clk, .i_rst,
    .i_por_delay_select(s), .i_config_pullup_disable(s), .i_reconfig_request_n(rq_n),
    .i_config_done(done), .o_config_load(load), .o_status(st));
  cms_cfg_src src (.i_clk, .i_load(load), .o_done(done));
  initial forever #10 i_clk = ~i_clk;
  task automatic check(input logic [4:0] seen, exp, input string what);
    num_checks++;
    if (seen !== exp) n_fail++;
    if (seen !== exp) $display("mismatch %s exp %h seen %h", what, exp, seen);
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic to_user();
    for (k = 0; k < 99 && st !== 5'h0C; k++) @(posedge i_clk) #1;
    check(st, 5'h0C, "user");
    if (k == 99) tally_and_finish();
  endtask : to_user
  task automatic power_up(input logic v, input logic [4:0] n);
    @(posedge i_clk) i_rst <= 1;
    s <= v;
    repeat (5) @(posedge i_clk);
    check(st, 5'h01, "rst status");
    check({4'h0, load}, 5'h00, "rst load");
    i_rst <= 0;
    for (k = 0; k < 30 && load !== 1'b1; k++) @(posedge i_clk) #1;
    check(5'(k), n, "por");
    check({1'b0, st[4:1]}, {4'h4, !v}, "load");
    to_user();
  endtask : power_up
  task automatic reconfig();
    @(posedge i_clk) rq_n <= 0;
    repeat (6) @(posedge i_clk);
    #1 check({1'b0, load, st[4:2]}, 5'h04, "held");
    @(posedge i_clk) rq_n <= 1;
    to_user();
  endtask : reconfig
  initial begin
    power_up(1'b1, 5'd6);
    power_up(1'b0, 5'd21);
    reconfig();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
